// ===== verilog/sysclk_consts.svh
// Purpose: offsets, fields, reset values and timing counts
// Assumes: 32-bit apb data, one register per aligned word
// Notes: definitions only
`ifndef SYSCLK_CONSTS_SVH
`define SYSCLK_CONSTS_SVH
`define CLK_CTRL_OFS 12'h000
`define HS_OSC_CTRL_OFS 12'h004
`define PWR_STATUS_OFS 12'h008
`define CLK_CTRL_RST 8'h00
`define HS_OSC_CTRL_RST 8'h01
`define SEL_LO 5
`define SEL_HI 7
`define HS_KEEP_BIT 1
`define LS_KEEP_BIT 0
`define OSC_EN_BIT 0
`define OSC_STB_BIT 1
`define SEL_SUB 3'h7
`define HS_DIV_W 6
`define SWITCH_BASE 4
`define HS_STABLE_NS 16000
`define PCLK_NS 25
`define HS_STABLE_CYC ((`HS_STABLE_NS + `PCLK_NS - 1) / `PCLK_NS)
`define LS_STABLE_CYC 8
`define CNT_W 12
`endif

// ===== verilog/sysclk_pkg.sv
// Purpose: types for the clock and power-mode controller
// Assumes: constants come from sysclk_consts.svh
// Notes: none
package sysclk_pkg;
    typedef enum logic [2:0] {
        run_st, deep_stop_st, idle_sub_only, idle_both_osc, idle_hs_only
    } pwr_mode_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic hs_rc_osc_on;
        logic ls_rc_osc_on;
        logic wdt_src_clk_on;
        logic sub_clk_on;
    } clk_gates_t;
    typedef struct packed {
        logic power_down_flag;
        logic wdt_timeout_flag;
    } pwr_flags_t;
endpackage : sysclk_pkg

// ===== verilog/sysclk_power_mode_ctrl.sv
// Purpose: system clock select, halt modes, oscillator control
// Assumes: halt, wdt and wake events are single pclk pulses
// Notes: oscillators are modelled by stable counters on pclk
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "sysclk_consts.svh"
module sysclk_power_mode_ctrl
    import sysclk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_exec,
    input wire logic wake_evt,
    input wire logic clr_wdt_exec,
    input wire logic wdt_timeout_evt,
    input wire logic wdt_enabled,
    output logic [2:0] sys_clk_sel,
    output logic cpu_on_hs,
    output logic [`HS_DIV_W-1:0] hs_div_mask,
    output clk_gates_t gates,
    output pwr_flags_t flags,
    output logic wdt_clear,
    output logic hold_state,
    output logic switch_busy
);
    logic [7:0] clk_ctrl_r;
    logic hs_en_r;
    logic hs_stable_r;
    logic ls_stable_r;
    logic [`CNT_W-1:0] hs_cnt_r;
    logic [3:0] ls_cnt_r;
    pwr_mode_t mode_r;
    pwr_mode_t mode_nxt;
    logic [2:0] active_sel_r;
    logic [3:0] sw_cnt_r;
    pwr_flags_t flags_r;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic halted;
    logic target_ready;
    logic sw_done;
    logic [31:0] rdata_nxt;
    clk_gates_t gates_nxt;

    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !penable && !pwrite && clk_en;
    assign halted = (mode_r != run_st);
    assign hit = (paddr == `CLK_CTRL_OFS) || (paddr == `HS_OSC_CTRL_OFS)
        || (paddr == `PWR_STATUS_OFS);

    // register writes; bits 4..2 never stored so they read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_ctrl_r <= `CLK_CTRL_RST;
        end else if (wr_en && !halted) begin
            if (paddr == `CLK_CTRL_OFS) begin
                clk_ctrl_r <= {pwdata[`SEL_HI:`SEL_LO], 3'h0,
                    pwdata[`HS_KEEP_BIT], pwdata[`LS_KEEP_BIT]};
            end
        end
    end

    // enable resets on so the cpu starts from the fast clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_en_r <= 1'b1;
        end else if (wr_en && !halted) begin
            if (paddr == `HS_OSC_CTRL_OFS) begin
                hs_en_r <= pwdata[`OSC_EN_BIT];
            end
        end
    end

    // apb answer, zero wait state; unmapped addresses error
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `CLK_CTRL_OFS: rdata_nxt = {24'h00_0000, clk_ctrl_r};
            `HS_OSC_CTRL_OFS: rdata_nxt = {30'h0, hs_stable_r, hs_en_r};
            `PWR_STATUS_OFS: rdata_nxt = {29'h0, mode_r == run_st,
                flags_r.power_down_flag, flags_r.wdt_timeout_flag};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data captured at setup so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (rd_en) begin
                prdata <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= psel && !penable && !hit;
        end
    end

    // hs oscillator settling; in run mode enable low drops the stable flag only while sub is selected, as fast selects keep the osc gate on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_cnt_r <= '0;
            hs_stable_r <= 1'b0;
        end else if (clk_en) begin
            if (!gates_nxt.hs_rc_osc_on) begin
                hs_cnt_r <= '0;
                hs_stable_r <= 1'b0;
            end else if (!hs_stable_r) begin
                if (hs_cnt_r == `CNT_W'(`HS_STABLE_CYC - 1)) begin
                    hs_stable_r <= 1'b1;
                end else begin
                    hs_cnt_r <= hs_cnt_r + `CNT_W'(1);
                end
            end
        end
    end

    // ls oscillator settling, same model
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_cnt_r <= 4'h0;
            ls_stable_r <= 1'b0;
        end else if (clk_en) begin
            if (!gates_nxt.ls_rc_osc_on) begin
                ls_cnt_r <= 4'h0;
                ls_stable_r <= 1'b0;
            end else if (!ls_stable_r) begin
                if (ls_cnt_r == 4'(`LS_STABLE_CYC - 1)) begin
                    ls_stable_r <= 1'b1;
                end else begin
                    ls_cnt_r <= ls_cnt_r + 4'h1;
                end
            end
        end
    end

    // halt mode selection from the two keep bits
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            run_st: begin
                if (halt_exec) begin
                    case ({clk_ctrl_r[`HS_KEEP_BIT],
                           clk_ctrl_r[`LS_KEEP_BIT]})
                        2'b00: mode_nxt = deep_stop_st;
                        2'b01: mode_nxt = idle_sub_only;
                        2'b11: mode_nxt = idle_both_osc;
                        default: mode_nxt = idle_hs_only;
                    endcase
                end
            end
            deep_stop_st, idle_sub_only, idle_both_osc, idle_hs_only: begin
                if (wake_evt) begin
                    mode_nxt = run_st;
                end
            end
            default: mode_nxt = run_st;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= run_st;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
        end
    end

    // clock gating per mode
    always_comb begin
        gates_nxt.cpu_clk_en = 1'b0;
        gates_nxt.hs_rc_osc_on = 1'b0;
        gates_nxt.ls_rc_osc_on = 1'b1;
        gates_nxt.sub_clk_on = 1'b0;
        gates_nxt.wdt_src_clk_on = 1'b1;
        case (mode_nxt)
            run_st: begin
                gates_nxt.cpu_clk_en = 1'b1;
                gates_nxt.sub_clk_on = 1'b1;
                // slow mode keeps hs only if enabled; fast needs it
                gates_nxt.hs_rc_osc_on = hs_en_r
                    || (clk_ctrl_r[`SEL_HI:`SEL_LO] != `SEL_SUB);
            end
            deep_stop_st: begin
                gates_nxt.ls_rc_osc_on = wdt_enabled;
                gates_nxt.wdt_src_clk_on = wdt_enabled;
            end
            idle_sub_only: begin
                gates_nxt.sub_clk_on = 1'b1;
            end
            idle_both_osc: begin
                gates_nxt.hs_rc_osc_on = 1'b1;
                gates_nxt.sub_clk_on = 1'b1;
            end
            idle_hs_only: begin
                gates_nxt.hs_rc_osc_on = 1'b1;
            end
            default: gates_nxt.cpu_clk_en = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gates <= '0;
        end else if (clk_en) begin
            gates <= gates_nxt;
        end
    end

    // freeze request goes out with the gates, same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_state <= 1'b0;
        end else if (clk_en) begin
            hold_state <= mode_nxt != run_st;
        end
    end

    // status flags; halt and the timeout pulse together: timeout wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= '0;
        end else if (clk_en) begin
            if (halt_exec && !halted) begin
                flags_r.power_down_flag <= 1'b1;
                flags_r.wdt_timeout_flag <= 1'b0;
            end else if (clr_wdt_exec) begin
                flags_r <= '0;
            end
            if (wdt_timeout_evt) begin
                flags_r.wdt_timeout_flag <= 1'b1;
            end
        end
    end

    // one pulse per halt or clear instruction; counter lives outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_clear <= 1'b0;
        end else if (clk_en) begin
            wdt_clear <= (halt_exec && !halted) || clr_wdt_exec;
        end
    end

    assign flags = flags_r;

    // clock switch: wait for target stable, then fixed delay
    assign target_ready = (clk_ctrl_r[`SEL_HI:`SEL_LO] == `SEL_SUB)
        ? ls_stable_r : hs_stable_r;
    assign sw_done = (active_sel_r != clk_ctrl_r[`SEL_HI:`SEL_LO])
        && target_ready && (sw_cnt_r == 4'(`SWITCH_BASE - 1));

    // a fixed count, not the worst case; software still waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_cnt_r <= 4'h0;
        end else if (clk_en) begin
            if (sw_done || !target_ready
                || active_sel_r == clk_ctrl_r[`SEL_HI:`SEL_LO]) begin
                sw_cnt_r <= 4'h0;
            end else begin
                sw_cnt_r <= sw_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_sel_r <= 3'h0;
        end else if (clk_en) begin
            if (sw_done) begin
                active_sel_r <= clk_ctrl_r[`SEL_HI:`SEL_LO];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_sel <= 3'h0;
        end else if (clk_en) begin
            sys_clk_sel <= active_sel_r;
        end
    end

    // sub selects cpu from the ls oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_on_hs <= 1'b1;
        end else if (clk_en) begin
            cpu_on_hs <= active_sel_r != `SEL_SUB;
        end
    end

    // mask bit i set when the ratio needs more than i halvings
    for (genvar i = 0; i < `HS_DIV_W; i++) begin : g_div
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hs_div_mask[i] <= 1'b0;
            end else if (clk_en) begin
                hs_div_mask[i] <= (active_sel_r != `SEL_SUB)
                    && (active_sel_r > 3'(i));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_busy <= 1'b0;
        end else if (clk_en) begin
            switch_busy <= active_sel_r != clk_ctrl_r[`SEL_HI:`SEL_LO];
        end
    end
endmodule : sysclk_power_mode_ctrl

// ===== dv/sysclk_power_mode_ctrl_props.sv
// Purpose: concurrent checks on the clock and power-mode ports
// Assumes: clk_en held high by the bench
// Notes: bound from the bench top file
`timescale 1ns/10ps
`include "sysclk_consts.svh"
module sysclk_power_mode_ctrl_props
    import sysclk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic halt_exec,
    input wire logic wdt_timeout_evt,
    input wire logic wdt_enabled,
    input wire logic [2:0] sys_clk_sel,
    input wire logic [`HS_DIV_W-1:0] hs_div_mask,
    input wire clk_gates_t gates,
    input wire pwr_flags_t flags,
    input wire logic wdt_clear,
    input wire logic hold_state,
    input wire logic switch_busy
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence halt_go;
    halt_exec && clk_en && !hold_state;
endsequence
a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
a_halt_hold: assert property (halt_go |-> ##[1:2] hold_state && !gates.cpu_clk_en)
    else $error("halt did not stop cpu");
a_halt_flags: assert property (halt_go ##0 !wdt_timeout_evt |-> ##[1:2] flags == 2'b10)
    else $error("halt flags wrong");
a_halt_wdtclr: assert property (halt_go |-> ##[1:2] wdt_clear)
    else $error("watchdog not cleared");
a_deep_wdt: assert property (hold_state && !gates.hs_rc_osc_on && !gates.sub_clk_on |-> gates.wdt_src_clk_on == wdt_enabled)
    else $error("deep stop wdt clock wrong");
a_sub_ls: assert property (hold_state && gates.sub_clk_on |-> gates.ls_rc_osc_on)
    else $error("sub clock without ls osc");
a_div_mask: assert property ($stable(sys_clk_sel) && $stable(hs_div_mask) |-> hs_div_mask == ((sys_clk_sel == 3'h7) ? 6'h00 : 6'((7'h01 << sys_clk_sel) - 7'h01)))
    else $error("divide mask wrong");
a_sel_ro: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[4:2] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("unused bits not zero");
a_stb_en: assert property (pready && !pwrite && paddr == 12'h004 && !prdata[0] |-> !prdata[1])
    else $error("stable while disabled");
a_switch_bound: assert property ($rose(switch_busy) |-> ##[1:700] !switch_busy)
    else $error("switch too slow");
a_tmo_set: assert property (wdt_timeout_evt && clk_en |-> ##[1:2] flags.wdt_timeout_flag)
    else $error("timeout flag not set");
c_halt: cover property (halt_go);
c_switch: cover property ($rose(switch_busy));
c_err: cover property (pslverr);
endmodule : sysclk_power_mode_ctrl_props

// ===== dv/sysclk_power_mode_ctrl_bench.sv
// Purpose: self-checking bench for the clock and power-mode block
// Assumes: zero-wait apb, event inputs are one-cycle pulses
// Notes: writes while halted must be dropped
`timescale 1ns/10ps
module sysclk_power_mode_ctrl_bench
    import sysclk_pkg::*;
;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic wdt_enabled = 0, pready, pslverr, e, cpu_on_hs, wdt_clear;
logic hold_state, switch_busy;
logic [3:0] evts = 4'h0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, r;
logic [2:0] sys_clk_sel;
logic [5:0] hs_div_mask;
clk_gates_t gates;
pwr_flags_t flags;
int num_errors = 0, comparisons = 0, n;
// {on_hs, mask, sel}
localparam logic [9:0] sel_rows [8] = '{10'h200, 10'h209, 10'h21A,
    10'h23B, 10'h27C, 10'h2FD, 10'h3FE, 10'h007};
// {hs_keep, ls_keep, wdt_en, gates}
localparam logic [7:0] halt_rows [5] = '{8'h00, 8'h26, 8'h67, 8'hEF,
    8'hAE};
always #12.5 pclk = ~pclk;
sysclk_power_mode_ctrl uut(.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_exec(evts[0]), .wake_evt(evts[1]),
    .clr_wdt_exec(evts[3]), .wdt_timeout_evt(evts[2]),
    .wdt_enabled(wdt_enabled), .sys_clk_sel(sys_clk_sel),
    .cpu_on_hs(cpu_on_hs), .hs_div_mask(hs_div_mask), .gates(gates),
    .flags(flags), .wdt_clear(wdt_clear), .hold_state(hold_state),
    .switch_busy(switch_busy));
task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        num_errors++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask : chk
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
        @(posedge pclk);
        k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
        num_errors++;
        $display("BAD %0t no apb answer", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask : apb
task cyc(input int c);
    repeat (c) @(posedge pclk);
endtask : cyc
task pulse(input int b);
    @(posedge pclk);
    evts[b] <= 1'b1;
    @(posedge pclk);
    evts[b] <= 1'b0;
endtask : pulse
// busy may rise late, so give it two edges first
task settle;
    cyc(2);
    n = 0;
    while (switch_busy !== 1'b0 && n < 1000) begin
        @(posedge pclk);
        n++;
    end
    if (switch_busy !== 1'b0) begin
        num_errors++;
        $display("BAD %0t switch never ended", $time);
    end
    cyc(2);
endtask : settle
task end_of_test;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask : end_of_test
initial begin
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    chk({cpu_on_hs, gates, sys_clk_sel}, {1'b1, 5'h1F, 3'h0});
    apb(0, 12'h000, 0);
    chk(r, 0);
    apb(0, 12'h004, 0);
    chk(r & 1, 1);
    apb(0, 12'h00C, 0);
    chk(e, 1);
    chk(r, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
        apb(1, 12'h000, {24'h0, sel_rows[i][2:0], 5'h00});
        settle;
        chk({cpu_on_hs, hs_div_mask, sys_clk_sel}, sel_rows[i]);
        apb(0, 12'h000, 0);
        chk(r, {sel_rows[i][2:0], 5'h00});
    end
    $display("test select done");
    apb(1, 12'h004, 0);
    cyc(2);
    chk(gates.hs_rc_osc_on, 0);
    apb(0, 12'h004, 0);
    chk(r, 0);
    apb(1, 12'h004, 1);
    apb(0, 12'h004, 0);
    chk(r, 1);
    n = 0;
    while (r[1] !== 1'b1 && n < 400) begin
        apb(0, 12'h004, 0);
        n++;
    end
    chk(r, 3);
    chk(n > 150, 1);
    $display("test oscillator done");
    for (int i = 0; i < 5; i++) begin
        wdt_enabled <= halt_rows[i][5];
        apb(1, 12'h000, halt_rows[i][7:6]);
        settle;
        pulse(2);
        pulse(0);
        cyc(2);
        chk({hold_state, gates, flags}, {1'b1, halt_rows[i][4:0], 2'b10});
        apb(1, 12'h000, 32'hE3);
        pulse(1);
        cyc(2);
        chk(hold_state, 0);
        apb(0, 12'h000, 0);
        chk(r, halt_rows[i][7:6]);
    end
    $display("test halt done");
    pulse(3);
    cyc(2);
    chk(flags, 0);
    apb(0, 12'h008, 0);
    chk(r, 4);
    cyc(1);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    apb(0, 12'h000, 0);
    chk(r, 0);
    $display("test flags and reset done");
    end_of_test;
end
// whole run needs about 1600 cycles
initial begin
    #500000;
    num_errors++;
    end_of_test;
end
endmodule : sysclk_power_mode_ctrl_bench
bind sysclk_power_mode_ctrl sysclk_power_mode_ctrl_props props_i(
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
    .wdt_timeout_evt(wdt_timeout_evt), .wdt_enabled(wdt_enabled),
    .sys_clk_sel(sys_clk_sel), .hs_div_mask(hs_div_mask), .gates(gates),
    .flags(flags), .wdt_clear(wdt_clear), .hold_state(hold_state),
    .switch_busy(switch_busy));
